// ---- rtl/far_params.svh ----
/*
  Constants for the fault auto-reset and restart supervisor: register
  offsets, field positions, reset values and timing counts.
  Assumes inclusion by bare name from the top module and the bench.
*/
`ifndef FAR_PARAMS_SVH
`define FAR_PARAMS_SVH

`define FAR_CLK_HZ          250000000
`define FAR_QUIET_MINUTES   10
`define FAR_QUIET_SECONDS   (`FAR_QUIET_MINUTES * 60)

`define FAR_OFS_CTRL        12'h000
`define FAR_OFS_DELAY       12'h004
`define FAR_OFS_LIMIT       12'h008
`define FAR_OFS_STATUS      12'h00C

`define FAR_CTRL_SEL_LSB    0
`define FAR_CTRL_EN_BIT     2
`define FAR_CTRL_DH_BIT     3
`define FAR_CTRL_SCOPE_BIT  4

`define FAR_CTRL_RST        32'h0000_0000
`define FAR_DELAY_RST       16'h0005
`define FAR_LIMIT_RST       8'h05

`define FAR_SEL_NEVER       2'h0
`define FAR_SEL_ALWAYS      2'h1
`define FAR_SEL_RUNNING     2'h2

`define FAR_TRIP_UNDERVOLT  4'h1

`define FAR_RESP_OKAY       2'h0
`define FAR_RESP_SLVERR     2'h2

`endif

// ---- rtl/far_pkg.sv ----
/*
  Types for the fault auto-reset and restart supervisor.
  Assumes far_params.svh for the numeric constants.
*/
`default_nettype none
package far_pkg;

  typedef enum logic [1:0] {
    FAR_IDLE   = 2'b00,
    FAR_WAIT   = 2'b01,
    FAR_LOCKED = 2'b10
  } far_state_t;

  typedef struct packed {
    logic       scope_every_fault;
    logic       delayed_healthy_option;
    logic       fault_autoclear_enable;
    logic [1:0] power_up_start_select;
  } far_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] kind;
  } far_trip_t;

endpackage
`default_nettype wire

// ---- rtl/far_tick_div.sv ----
/*
  One-cycle enable divider for the seconds timebase.
  Assumes a single clock; restart realigns the phase to the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module far_tick_div #(
  parameter int unsigned DIV = 250000000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic restart,
  output logic      tick
);

  logic [31:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || restart || tick) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  assign tick = (cnt_q == 32'(DIV - 1));

endmodule
`default_nettype wire

// ---- rtl/far_top.sv ----
/*
  Fault auto-reset and power-up restart supervisor, AXI4-Lite slave.
  Assumes trips and run status come from logic on aclk; mains_ok is
  an asynchronous pin. This logic stays powered across mains loss.
*/
// Overview of operation
// RULE_01: Select 0 never starts the motor when mains returns.
// RULE_02: Select 1 always starts the motor when mains returns.
// RULE_03: Select 2 starts on mains return only if it ran when mains was lost.
// RULE_04: With autoclear enabled a trip is cleared once the delay has run out.
// RULE_05: The delay is a count of whole seconds timed on a seconds tick.
// RULE_06: At the attempt limit further trips of the same type stay latched.
// RULE_07: A trip of another type is still cleared after the limit is hit.
// RULE_08: Ten minutes without any trip clears the attempt count.
// RULE_09: With delayed healthy set the normal flag stays 1 through trips that will auto-clear.
// RULE_10: With delayed healthy clear the normal flag drops to 0 on every trip.
// RULE_11: Under the undervoltage-only scope only undervoltage trips auto-clear.
// RULE_12: Under the every-fault scope all trip types auto-clear.
// RULE_13: A running record is kept and frozen while mains is absent.
// RULE_14: Each auto-clear bumps the count for the same type as the last (else sets it to 1) and records the trip type.
`timescale 1ns/1ps
`default_nettype none
`include "far_params.svh"

module far_top #(
  parameter int unsigned CYCLES_PER_SEC = `FAR_CLK_HZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mains_ok,
  input  wire logic        trip_valid,
  input  wire logic [3:0]  trip_kind,
  input  wire logic        run_active,
  input  wire logic        manual_reset,
  output logic             autostart_pulse,
  output logic             fault_clear_pulse,
  output logic             fault_latched,
  output logic             drive_normal_flag
);

  far_pkg::far_cfg_t   cfg_q;
  far_pkg::far_trip_t  trip;
  far_pkg::far_state_t state_q;
  logic [15:0]         delay_q;
  logic [7:0]          limit_q;
  logic                aw_got_q;
  logic                w_got_q;
  logic [11:0]         awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                mains_m_q;
  logic                mains_s_q;
  logic                mains_prev_q;
  logic                was_running_q;
  logic [7:0]          count_q;
  logic [3:0]          last_kind_q;
  logic [3:0]          trip_kind_wait_q;
  logic [15:0]         sec_cnt_q;
  logic [9:0]          quiet_q;
  logic                sec_tick;
  logic                power_up;
  logic                in_scope;
  logic                exhausted;
  logic                eligible;
  logic                delay_done;
  logic                do_write;

  assign trip.valid = trip_valid;
  assign trip.kind  = trip_kind;

  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign do_write      = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FAR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q[11:2] == `FAR_OFS_CTRL >> 2 || awaddr_q[11:2] == `FAR_OFS_DELAY >> 2 ||
          awaddr_q[11:2] == `FAR_OFS_LIMIT >> 2 || awaddr_q[11:2] == `FAR_OFS_STATUS >> 2) begin
        s_axi_bresp <= `FAR_RESP_OKAY;
      end else begin
        s_axi_bresp <= `FAR_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; writes to status are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q   <= far_pkg::far_cfg_t'(5'(`FAR_CTRL_RST));
      delay_q <= `FAR_DELAY_RST;
      limit_q <= `FAR_LIMIT_RST;
    end else if (do_write) begin
      if (awaddr_q[11:2] == `FAR_OFS_CTRL >> 2) begin
        cfg_q <= far_pkg::far_cfg_t'(5'(merge({27'h0, cfg_q}, wdata_q, wstrb_q)));
      end else if (awaddr_q[11:2] == `FAR_OFS_DELAY >> 2) begin
        delay_q <= 16'(merge({16'h0, delay_q}, wdata_q, wstrb_q));
      end else if (awaddr_q[11:2] == `FAR_OFS_LIMIT >> 2) begin
        limit_q <= 8'(merge({24'h0, limit_q}, wdata_q, wstrb_q));
      end
    end
  end

  // Read channel, one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `FAR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `FAR_RESP_OKAY;
      if (s_axi_araddr[11:2] == `FAR_OFS_CTRL >> 2) begin
        s_axi_rdata <= {27'h0, cfg_q};
      end else if (s_axi_araddr[11:2] == `FAR_OFS_DELAY >> 2) begin
        s_axi_rdata <= {16'h0, delay_q};
      end else if (s_axi_araddr[11:2] == `FAR_OFS_LIMIT >> 2) begin
        s_axi_rdata <= {24'h0, limit_q};
      end else if (s_axi_araddr[11:2] == `FAR_OFS_STATUS >> 2) begin
        s_axi_rdata <= {14'h0, state_q, was_running_q, drive_normal_flag, fault_latched,
                        mains_s_q, last_kind_q, count_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `FAR_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Mains pin synchroniser and power-up edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mains_m_q    <= 1'b0;
      mains_s_q    <= 1'b0;
      mains_prev_q <= 1'b0;
    end else begin
      mains_m_q    <= mains_ok;
      mains_s_q    <= mains_m_q;
      mains_prev_q <= mains_s_q;
    end
  end

  assign power_up = mains_s_q && !mains_prev_q;

  // Record frozen while mains is absent, so it holds the state at loss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      was_running_q <= 1'b0;
    end else if (mains_s_q && !power_up) begin
      was_running_q <= run_active; // [RULE_13]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      autostart_pulse <= 1'b0;
    end else if (power_up) begin
      case (cfg_q.power_up_start_select)
        `FAR_SEL_ALWAYS:  autostart_pulse <= 1'b1;          // [RULE_02]
        `FAR_SEL_RUNNING: autostart_pulse <= was_running_q; // [RULE_03]
        default:          autostart_pulse <= 1'b0;          // [RULE_01]
      endcase
    end else begin
      autostart_pulse <= 1'b0;
    end
  end

  // Trip qualification
  assign in_scope   = cfg_q.scope_every_fault || trip.kind == `FAR_TRIP_UNDERVOLT; // [RULE_11] [RULE_12]
  assign exhausted  = count_q >= limit_q && trip.kind == last_kind_q;              // [RULE_06] [RULE_07]
  assign eligible   = cfg_q.fault_autoclear_enable && in_scope && !exhausted && limit_q != 8'h00;
  assign delay_done = sec_cnt_q >= delay_q;

  // Divider restarts on each trip so the first second is whole
  far_tick_div #(
    .DIV (CYCLES_PER_SEC)
  ) u_sec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (trip.valid),
    .tick    (sec_tick)
  );

  // A trip in the same cycle as a clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q           <= far_pkg::FAR_IDLE;
      fault_clear_pulse <= 1'b0;
      sec_cnt_q         <= 16'h0000;
    end else begin
      fault_clear_pulse <= 1'b0;
      if (trip.valid) begin
        sec_cnt_q <= 16'h0000;
        state_q   <= eligible ? far_pkg::FAR_WAIT : far_pkg::FAR_LOCKED;
      end else begin
        case (state_q)
          far_pkg::FAR_WAIT: begin
            if (delay_done) begin
              state_q           <= far_pkg::FAR_IDLE; // [RULE_04]
              fault_clear_pulse <= 1'b1;
            end else if (sec_tick) begin
              sec_cnt_q <= sec_cnt_q + 16'h0001; // [RULE_05]
            end
          end
          far_pkg::FAR_LOCKED: begin
            if (manual_reset) begin
              state_q <= far_pkg::FAR_IDLE;
            end
          end
          default: state_q <= far_pkg::FAR_IDLE;
        endcase
      end
    end
  end

  assign fault_latched = state_q != far_pkg::FAR_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_normal_flag <= 1'b1;
    end else if (trip.valid) begin
      drive_normal_flag <= cfg_q.delayed_healthy_option && eligible && drive_normal_flag; // [RULE_09] [RULE_10]
    end else if (state_q == far_pkg::FAR_IDLE || fault_clear_pulse) begin
      drive_normal_flag <= 1'b1;
    end else if (state_q == far_pkg::FAR_LOCKED) begin
      drive_normal_flag <= 1'b0;
    end
  end

  // Quiet window; the window clear on a trip beats an increment
  always_ff @(posedge aclk) begin
    if (!aresetn || trip.valid) begin
      quiet_q <= 10'h000;
    end else if (sec_tick && quiet_q != 10'(`FAR_QUIET_SECONDS)) begin
      quiet_q <= quiet_q + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q     <= 8'h00;
      last_kind_q <= 4'h0;
    end else if (state_q == far_pkg::FAR_WAIT && !trip.valid && delay_done) begin
      last_kind_q <= trip_kind_wait_q;
      count_q     <= (trip_kind_wait_q == last_kind_q) ? count_q + 8'h01 : 8'h01; // [RULE_14]
    end else if (quiet_q == 10'(`FAR_QUIET_SECONDS)) begin
      count_q <= 8'h00; // [RULE_08]
    end
  end

  // Type of the trip being waited on

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_kind_wait_q <= 4'h0;
    end else if (trip.valid) begin
      trip_kind_wait_q <= trip.kind;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence pwr_sel_s(logic [1:0] sel);
    power_up && cfg_q.power_up_start_select == sel;
  endsequence

  sequence trip_s;
    trip.valid;
  endsequence

  never_start_a: assert property (pwr_sel_s(`FAR_SEL_NEVER) |=> !autostart_pulse) // [RULE_01]
    else $error("autostart with select 0");
  always_start_a: assert property (pwr_sel_s(`FAR_SEL_ALWAYS) |=> autostart_pulse) // [RULE_02]
    else $error("no autostart with select 1");
  running_start_a: assert property (pwr_sel_s(`FAR_SEL_RUNNING) |=> autostart_pulse == $past(was_running_q)) // [RULE_03]
    else $error("select 2 start does not follow record");
  clear_after_delay_a: assert property (fault_clear_pulse |-> $past(state_q) == far_pkg::FAR_WAIT
                                        && $past(sec_cnt_q) >= $past(delay_q)) // [RULE_04] [RULE_05]
    else $error("clear before delay");
  limit_lock_a: assert property (trip_s ##0 exhausted |=> state_q == far_pkg::FAR_LOCKED) // [RULE_06]
    else $error("exhausted trip not locked");
  other_kind_a: assert property (trip_s ##0 (eligible && trip.kind != last_kind_q)
                                 |=> state_q == far_pkg::FAR_WAIT) // [RULE_07]
    else $error("different type not reset");
  quiet_clear_a: assert property (quiet_q == 10'(`FAR_QUIET_SECONDS) && state_q != far_pkg::FAR_WAIT
                                  |=> count_q == 8'h00) // [RULE_08]
    else $error("count not cleared after quiet window");
  healthy_hold_a: assert property (trip_s ##0 (cfg_q.delayed_healthy_option && eligible && drive_normal_flag)
                                   |=> drive_normal_flag) // [RULE_09]
    else $error("normal flag dropped on pending reset");
  healthy_drop_a: assert property (trip_s ##0 !cfg_q.delayed_healthy_option |=> !drive_normal_flag) // [RULE_10]
    else $error("normal flag held with option 0");
  uv_scope_a: assert property (trip_s ##0 (!cfg_q.scope_every_fault && trip.kind != `FAR_TRIP_UNDERVOLT)
                               |=> state_q == far_pkg::FAR_LOCKED) // [RULE_11]
    else $error("non-undervoltage trip cleared");
  count_step_a: assert property (fault_clear_pulse |-> count_q != 8'h00 && last_kind_q == trip_kind_wait_q) // [RULE_14]
    else $error("count or type not recorded");

endmodule
`default_nettype wire

// ---- tb/far_plant_model.sv ----
/*
  Model of the drive side around the supervisor: mains monitor, fault
  detectors, run sequencer and the operator's fault reset.
  Assumes the bench calls its tasks; all changes follow a rising aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module far_plant_model (
  input  wire logic       aclk,
  output logic            mains_ok,
  output logic            trip_valid,
  output logic [3:0]      trip_kind,
  output logic            run_active,
  output logic            manual_reset
);
  initial begin
    mains_ok     = 1'b1;
    trip_valid   = 1'b0;
    trip_kind    = 4'h0;
    run_active   = 1'b0;
    manual_reset = 1'b0;
  end

  task automatic trip(input logic [3:0] k);
    @(posedge aclk);
    trip_valid <= 1'b1;
    trip_kind  <= k;
    @(posedge aclk);
    trip_valid <= 1'b0;
    // Kind means nothing without the strobe, so do not leave it parked
    trip_kind  <= ~k;
  endtask

  task automatic clear_lock();
    @(posedge aclk);
    manual_reset <= 1'b1;
    @(posedge aclk);
    manual_reset <= 1'b0;
  endtask

  // Motor stops while mains is away, as a real drive would
  task automatic power_cycle(input logic run_at_loss);
    @(posedge aclk);
    run_active <= run_at_loss;
    repeat (4) @(posedge aclk);
    mains_ok <= 1'b0;
    repeat (3) @(posedge aclk);
    run_active <= 1'b0;
    repeat (4) @(posedge aclk);
    mains_ok <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ---- tb/far_top_tb_top.sv ----
/*
  Self-checking bench for the supervisor: AXI4-Lite register tasks and
  trip, mains and reset sequences with expected outcomes.
  Assumes a 10-cycle second so delays and the quiet time stay short.
*/
`timescale 1ns/1ps
`default_nettype none
`include "far_params.svh"

module far_top_tb_top;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        mains_ok;
  logic        trip_valid;
  logic [3:0]  trip_kind;
  logic        run_active;
  logic        manual_reset;
  logic        autostart_pulse;
  logic        fault_clear_pulse;
  logic        fault_latched;
  logic        drive_normal_flag;
  int          error_cnt;
  int          samples_checked;
  int          cyc;
  logic [31:0] d;
  logic [1:0]  r;

  far_top #(.CYCLES_PER_SEC(10)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mains_ok(mains_ok), .trip_valid(trip_valid), .trip_kind(trip_kind),
    .run_active(run_active), .manual_reset(manual_reset),
    .autostart_pulse(autostart_pulse), .fault_clear_pulse(fault_clear_pulse),
    .fault_latched(fault_latched), .drive_normal_flag(drive_normal_flag));

  far_plant_model i_plant (
    .aclk(aclk), .mains_ok(mains_ok), .trip_valid(trip_valid), .trip_kind(trip_kind),
    .run_active(run_active), .manual_reset(manual_reset));

  always #2 aclk = ~aclk;

  // Hang guard, well above the roughly 6500 cycles of the sequence
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Handshakes looked at on the falling edge, acted on at the next rise
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic at, wt, bt;
    bt = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!bt) begin
      @(negedge aclk);
      at = awvalid & awready;
      wt = wvalid & wready;
      bt = bvalid & bready;
      rs = bresp;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic at, rt;
    rt = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!rt) begin
      @(negedge aclk);
      at = arvalid & arready;
      rt = rvalid & rready;
      v  = rdata;
      rs = rresp;
      @(posedge aclk);
      if (at) arvalid <= 1'b0;
      if (rt) rready <= 1'b0;
    end
  endtask

  task automatic status(input logic [7:0] cnt, input logic [3:0] kind, input logic [1:0] st);
    rd(`FAR_OFS_STATUS, d, r);
    chk("attempt_count", cnt, d[7:0]);
    chk("last_kind", kind, d[11:8]);
    chk("state", st, d[17:16]);
  endtask

  // Delay is 2 s of 10 cycles, so the clear lands about 21 cycles on
  task automatic trip_run(input logic [3:0] k, input logic exp_clr, input logic exp_flag);
    int hit;
    hit = 0;
    i_plant.trip(k);
    @(negedge aclk);
    chk("normal_flag", exp_flag, drive_normal_flag);
    for (int n = 1; n <= 30; n++) begin
      @(negedge aclk);
      if (fault_clear_pulse === 1'b1 && hit == 0) hit = n;
    end
    chk("autoclear", exp_clr, hit != 0);
    if (exp_clr) chk("clear_delay", 1, hit >= 17 && hit <= 24);
  endtask

  task automatic powerup(input logic [1:0] sel, input logic run, input int exp);
    int pulses;
    pulses = 0;
    wr(`FAR_OFS_CTRL, {30'h0, sel}, r);
    i_plant.power_cycle(run);
    repeat (12) begin
      @(negedge aclk);
      if (autostart_pulse === 1'b1) pulses++;
    end
    chk("autostart", exp, pulses);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`FAR_OFS_CTRL, d, r);
    chk("ctrl_reset", `FAR_CTRL_RST, d);
    rd(`FAR_OFS_DELAY, d, r);
    chk("delay_reset", 32'h5, d);
    rd(`FAR_OFS_LIMIT, d, r);
    chk("limit_reset", 32'h5, d);
    @(negedge aclk);
    chk("flag_reset", 1, drive_normal_flag);
    rd(12'h010, d, r);
    chk("unmapped_rresp", `FAR_RESP_SLVERR, r);
    wr(12'h010, 32'h1, r);
    chk("unmapped_bresp", `FAR_RESP_SLVERR, r);
    powerup(2'h0, 1'b1, 0);
    powerup(2'h1, 1'b0, 1);
    powerup(2'h2, 1'b0, 0);
    powerup(2'h2, 1'b1, 1);
    // Only byte 0 enabled, so the 33 in byte 1 must not land
    wstrb <= 4'h1;
    wr(`FAR_OFS_DELAY, 32'h0000_3302, r);
    wstrb <= 4'hF;
    rd(`FAR_OFS_DELAY, d, r);
    chk("delay_strobe", 32'h2, d);
    wr(`FAR_OFS_DELAY, 32'h2, r);
    wr(`FAR_OFS_LIMIT, 32'h2, r);
    wr(`FAR_OFS_CTRL, 32'h14, r);
    trip_run(4'h3, 1'b1, 1'b0);
    status(8'h1, 4'h3, 2'h0);
    trip_run(4'h3, 1'b1, 1'b0);
    status(8'h2, 4'h3, 2'h0);
    trip_run(4'h3, 1'b0, 1'b0);
    chk("latched", 1, fault_latched);
    status(8'h2, 4'h3, 2'h2);
    i_plant.clear_lock();
    trip_run(4'h5, 1'b1, 1'b0);
    status(8'h1, 4'h5, 2'h0);
    wr(`FAR_OFS_CTRL, 32'h1C, r);
    trip_run(4'h5, 1'b1, 1'b1);
    trip_run(4'h5, 1'b0, 1'b0);
    i_plant.clear_lock();
    wr(`FAR_OFS_CTRL, 32'h04, r);
    trip_run(4'h2, 1'b0, 1'b0);
    i_plant.clear_lock();
    trip_run(4'h1, 1'b1, 1'b0);
    status(8'h1, 4'h1, 2'h0);
    // Ten minutes of 10-cycle seconds, plus margin
    repeat (6050) @(posedge aclk);
    rd(`FAR_OFS_STATUS, d, r);
    chk("quiet_count", 0, d[7:0]);
    summarize();
  end
endmodule

`default_nettype wire
